// ===== imc_master.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
module imc_master
  #(
  parameter int unsigned QTR = imc_pkg::QTR_CYCLES
  )
  (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Two-wire bus pins, open drain.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
  );
  import imc_pkg::*;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [15:0] tick_cnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    imc_fsm_t fsm;
    imc_op_t op;
    logic en;
    logic smart;
    logic ackch;
    logic [7:0] target;
    logic [7:0] shreg;
    logic f_rif;
    logic f_wif;
    logic f_hold;
    logic last_slave_ack;
    logic f_arb;
    logic f_berr;
    imc_line_t line;
    logic arb_now;
    logic rd_byte;
    logic is_addr;
    logic [3:0] mon_cnt;
    logic mon_fresh;
    logic scl_oe;
    logic sda_oe;
    logic pend;
    logic p_write;
    logic [5:0] p_idx;
    logic [7:0] rdat;
    logic hready;
  } imc_state_t;

  localparam imc_state_t RST_VAL = '{fsm: ST_IDLE, op: OP_RSTART, line: LS_UNKNOWN,
    hready: 1'b1, default: '0};

  imc_state_t st;
  imc_state_t nx;
  logic [7:0] wdat;
  logic acc_wr;
  logic acc_rd;
  logic parked;
  logic held;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic tick;
  logic adv;
  logic launch;
  logic launch_ack;
  imc_op_t launch_op;
  logic give_up;
  logic berr_now;
  logic flush;

  // Maps an operation onto the engine state that carries it out.
  function automatic imc_fsm_t op_state(input imc_op_t op);
    unique case (op)
      OP_RSTART: return ST_START;
      OP_STOP: return ST_STOP;
      default: return ST_XFER;
    endcase
  endfunction

  // Next-state logic: bus slave, software effects, bit engine, bus monitor.
  always_comb
  begin
    nx = st;
    wdat = hwdata[7:0];
    acc_wr = st.pend & st.p_write;
    acc_rd = st.pend & ~st.p_write;
    parked = (st.fsm == ST_IDLE) | (st.fsm == ST_HOLD);
    held = st.fsm == ST_HOLD;
    start_seen = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
    stop_seen = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;
    scl_rise = st.scl_s & ~st.scl_d;
    scl_fall = ~st.scl_s & st.scl_d;
    tick = st.tick_cnt == 16'(QTR - 1);
    // A released SCL that a slave still holds low stretches the sample phase.
    adv = tick & ~((st.phase == PH_SAMPLE) & ~st.scl_s);
    launch = 1'b0;
    launch_ack = 1'b0;
    launch_op = OP_RSTART;
    give_up = 1'b0;
    berr_now = 1'b0;
    flush = 1'b0;

    // Pin inputs pass two flip-flops; the third stage gives edges.
    nx.scl_m = scl_i;
    nx.scl_s = st.scl_m;
    nx.scl_d = st.scl_s;
    nx.sda_m = sda_i;
    nx.sda_s = st.sda_m;
    nx.sda_d = st.sda_s;
    nx.tick_cnt = tick ? '0 : st.tick_cnt + 16'h0001;

    // Every transfer gets one wait state; effects happen in that cycle.
    nx.hready = 1'b1;
    nx.pend = 1'b0;
    if (hsel & htrans[1] & hready)
    begin
      nx.pend = 1'b1;
      nx.p_write = hwrite;
      nx.p_idx = haddr[7:2];
      nx.hready = 1'b0;
    end

    // Read data; unmapped words and reserved bits read as zero.
    if (acc_rd)
    begin
      case (st.p_idx)
        IDX_SETUP: nx.rdat = {6'h00, st.smart, st.en};
        IDX_CMD: nx.rdat = {5'h00, st.ackch, 2'h0};
        IDX_FLAGS: nx.rdat = {st.f_rif, st.f_wif, st.f_hold, st.last_slave_ack,
          st.f_arb, st.f_berr, st.line};
        IDX_TARGET: nx.rdat = st.target;
        IDX_SHIFT: nx.rdat = st.shreg;
        default: nx.rdat = 8'h00;
      endcase
    end

    if (acc_rd && (st.p_idx == IDX_SHIFT) && st.smart && held)
    begin
      nx.f_rif = 1'b0;
      nx.f_wif = 1'b0;
      nx.f_hold = 1'b0;
      launch = 1'b1;
      launch_ack = 1'b1;
      launch_op = OP_READ;
    end

    if (acc_wr)
    begin
      case (st.p_idx)
        IDX_SETUP:
        begin
          nx.en = wdat[EN_BIT];
          nx.smart = wdat[SMART_BIT];
        end
        IDX_CMD:
        begin
          nx.ackch = wdat[ACKCH_BIT];
          flush = wdat[FLUSH_BIT];
          if (!flush && held && (wdat[1:0] != cmd_nothing))
          begin
            nx.f_rif = 1'b0;
            nx.f_wif = 1'b0;
            nx.f_hold = 1'b0;
            launch = 1'b1;
            launch_ack = st.target[DIR_BIT];
            unique case (imc_cmd_t'(wdat[1:0]))
              cmd_restart: launch_op = OP_RSTART;
              cmd_stop: launch_op = OP_STOP;
              cmd_next_byte: launch_op = st.target[DIR_BIT] ? OP_READ : OP_WRITE;
              cmd_nothing: launch = 1'b0;
            endcase
          end
        end
        IDX_FLAGS:
        begin
          nx.f_rif = st.f_rif & ~wdat[RIF_BIT];
          nx.f_wif = st.f_wif & ~wdat[WIF_BIT];
          nx.f_hold = st.f_hold & ~wdat[HOLD_BIT];
          nx.f_arb = st.f_arb & ~wdat[ARB_BIT];
          nx.f_berr = st.f_berr & ~wdat[BERR_BIT];
          if ((wdat[1:0] == LS_IDLE) && st.en)
            nx.line = LS_IDLE;
        end
        IDX_TARGET:
        begin
          // Writes during a shift are dropped; the target is copied into the shifter.
          if (parked)
          begin
            nx.f_rif = 1'b0;
            nx.f_wif = 1'b0;
            nx.f_hold = 1'b0;
            nx.f_arb = 1'b0;
            nx.f_berr = 1'b0;
            nx.target = wdat;
            nx.shreg = wdat;
            if (st.line == LS_UNKNOWN)
            begin
              nx.f_wif = 1'b1;
              nx.f_berr = 1'b1;
              nx.fsm = ST_IDLE;
            end
            else if (st.line == LS_OWNER)
            begin
              launch = 1'b1;
              launch_ack = st.target[DIR_BIT];
              launch_op = OP_RSTART;
            end
            else
              nx.fsm = ST_WAITBUS;
          end
        end
        IDX_SHIFT:
        begin
          if (parked)
            nx.shreg = wdat;
          if (held)
          begin
            nx.f_rif = 1'b0;
            nx.f_wif = 1'b0;
            nx.f_hold = 1'b0;
            launch = 1'b1;
            launch_op = OP_WRITE;
          end
        end
        default: ;
      endcase
    end

    if (launch)
    begin
      nx.fsm = launch_ack ? ST_ACKOUT : op_state(launch_op);
      nx.op = launch_op;
      nx.phase = PH_DRIVE;
      nx.bitn = '0;
      nx.rd_byte = launch_op == OP_READ;
      nx.is_addr = 1'b0;
      nx.arb_now = 1'b0;
    end

    // Bit engine; the phase steps only in states that clock the bus.
    if (adv && !parked && (st.fsm != ST_WAITBUS))
      nx.phase = st.phase + 2'h1;
    unique case (st.fsm)
      ST_IDLE, ST_HOLD: ;
      ST_WAITBUS:
      begin
        if (st.line == LS_IDLE)
        begin
          nx.fsm = ST_START;
          nx.phase = PH_DRIVE;
        end
      end
      ST_START:
      begin
        if (adv)
        begin
          unique case (st.phase)
            PH_DRIVE: nx.sda_oe = 1'b0;
            PH_RISE: nx.scl_oe = 1'b0;
            PH_SAMPLE:
            begin
              if (!st.sda_s)
                give_up = 1'b1;
              else
                nx.sda_oe = 1'b1;
            end
            PH_FALL:
            begin
              nx.scl_oe = 1'b1;
              nx.fsm = ST_XFER;
              nx.bitn = '0;
              nx.is_addr = 1'b1;
              nx.rd_byte = 1'b0;
              nx.arb_now = 1'b0;
            end
          endcase
        end
      end
      ST_ACKOUT:
      begin
        if (adv)
        begin
          unique case (st.phase)
            PH_DRIVE: nx.sda_oe = ~st.ackch;
            PH_RISE: nx.scl_oe = 1'b0;
            PH_SAMPLE:
            begin
              if (st.ackch && !st.sda_s)
                give_up = 1'b1;
            end
            PH_FALL:
            begin
              nx.scl_oe = 1'b1;
              nx.fsm = op_state(st.op);
              nx.bitn = '0;
              nx.rd_byte = st.op == OP_READ;
            end
          endcase
        end
      end
      ST_XFER:
      begin
        if (adv)
        begin
          unique case (st.phase)
            PH_DRIVE:
            begin
              // After a loss only ones go out, so the byte still completes.
              if ((st.bitn == BIT_ACK_SLOT) || st.rd_byte || st.arb_now)
                nx.sda_oe = 1'b0;
              else
                nx.sda_oe = ~st.shreg[7];
            end
            PH_RISE: nx.scl_oe = 1'b0;
            PH_SAMPLE:
            begin
              if (st.bitn == BIT_ACK_SLOT)
                nx.last_slave_ack = st.sda_s;
              else
              begin
                nx.shreg = {st.shreg[6:0], st.sda_s};
                if (!st.rd_byte && st.shreg[7] && !st.sda_s && !st.arb_now)
                begin
                  nx.arb_now = 1'b1;
                  nx.f_arb = 1'b1;
                end
              end
            end
            PH_FALL:
            begin
              nx.scl_oe = 1'b1;
              nx.bitn = st.bitn + 4'h1;
              if (st.rd_byte && (st.bitn == BIT_LAST_DATA))
              begin
                nx.f_rif = 1'b1;
                nx.fsm = ST_HOLD;
                nx.f_hold = 1'b1;
              end
              else if (!st.rd_byte && (st.bitn == BIT_ACK_SLOT))
              begin
                if (st.arb_now)
                begin
                  nx.f_wif = 1'b1;
                  nx.fsm = ST_IDLE;
                  nx.scl_oe = 1'b0;
                  nx.sda_oe = 1'b0;
                  nx.line = LS_BUSY;
                end
                else if (st.is_addr && st.target[DIR_BIT] && !st.last_slave_ack)
                begin
                  nx.bitn = '0;
                  nx.rd_byte = 1'b1;
                  nx.is_addr = 1'b0;
                end
                else
                begin
                  nx.f_wif = 1'b1;
                  nx.fsm = ST_HOLD;
                  nx.f_hold = 1'b1;
                end
              end
            end
          endcase
        end
      end
      ST_STOP:
      begin
        if (adv)
        begin
          unique case (st.phase)
            PH_DRIVE: nx.sda_oe = 1'b1;
            PH_RISE: nx.scl_oe = 1'b0;
            PH_SAMPLE: nx.sda_oe = 1'b0;
            PH_FALL:
            begin
              nx.fsm = ST_IDLE;
              nx.line = LS_IDLE;
            end
          endcase
        end
      end
    endcase

    if (give_up)
    begin
      nx.f_arb = 1'b1;
      nx.f_wif = 1'b1;
      nx.fsm = ST_IDLE;
      nx.scl_oe = 1'b0;
      nx.sda_oe = 1'b0;
      nx.line = LS_BUSY;
    end

    if (st.en)
    begin
      if (scl_rise)
        nx.mon_cnt = (st.mon_cnt == MON_LAST) ? '0 : st.mon_cnt + 4'h1;
      if (scl_fall)
        nx.mon_fresh = 1'b0;
      if (start_seen)
      begin
        berr_now = st.mon_cnt > MON_EDGE_OK;
        nx.mon_cnt = '0;
        nx.mon_fresh = 1'b1;
        nx.line = (st.fsm == ST_START) ? LS_OWNER : LS_BUSY;
      end
      if (stop_seen)
      begin
        berr_now = (st.mon_cnt > MON_EDGE_OK) || st.mon_fresh;
        nx.mon_cnt = '0;
        nx.mon_fresh = 1'b0;
        nx.line = LS_IDLE;
      end
      // An error during our own operation ends it and reports write-complete.
      if (berr_now)
      begin
        nx.f_berr = 1'b1;
        if (!parked)
        begin
          // The lines are released here, so a hold or read completion that the engine enters in this cycle is not reported.
          nx.f_wif = 1'b1;
          nx.f_rif = 1'b0;
          nx.f_hold = 1'b0;
          nx.fsm = ST_IDLE;
          nx.scl_oe = 1'b0;
          nx.sda_oe = 1'b0;
        end
      end
    end

    if (!nx.en || flush)
    begin
      nx.fsm = ST_IDLE;
      nx.line = LS_UNKNOWN;
      nx.scl_oe = 1'b0;
      nx.sda_oe = 1'b0;
      nx.f_hold = 1'b0;
      nx.mon_cnt = '0;
      nx.mon_fresh = 1'b0;
    end
    if (flush)
    begin
      nx.target = '0;
      nx.shreg = '0;
    end
  end

  // All state in one register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st <= RST_VAL;
    else
      st <= nx;
  end

  // The pins are only ever pulled low, so the output levels are fixed.
  assign hrdata = {24'h00_0000, st.rdat};
  assign hreadyout = st.hready;
  assign hresp = 1'b0;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = st.scl_oe;
  assign sda_oe = st.sda_oe;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_cmd_reads_zero: assert property (
    acc_rd && (st.p_idx == IDX_CMD) |=> hreadyout && (hrdata[1:0] == 2'h0))
    else $error("Command field read back nonzero.");
  chk_flush_clears: assert property (
    acc_wr && (st.p_idx == IDX_CMD) && wdat[FLUSH_BIT]
    |=> (st.target == 8'h00) && (st.shreg == 8'h00) && (st.line == LS_UNKNOWN))
    else $error("Flush left state behind.");
  chk_off_unknown: assert property (
    !st.en |-> (st.line == LS_UNKNOWN) && !st.scl_oe && !st.sda_oe)
    else $error("Disabled master touches bus.");
  chk_target_clears: assert property (
    acc_wr && (st.p_idx == IDX_TARGET) && parked && (st.line != LS_UNKNOWN)
    |=> !st.f_arb && !st.f_rif && !st.f_hold)
    else $error("Target write kept flags.");
  chk_unknown_error: assert property (
    acc_wr && (st.p_idx == IDX_TARGET) && parked && !st.en |=> st.f_wif && st.f_berr)
    else $error("Unknown bus did not flag error.");
  chk_flags_exclusive: assert property (
    !(st.f_rif && st.f_wif))
    else $error("Read and write flags both set.");
  chk_hold_scl_low: assert property (
    st.f_hold |-> (st.fsm == ST_HOLD) && st.scl_oe)
    else $error("Hold flag without SCL held.");
  chk_ack_drive: assert property (
    (st.fsm == ST_ACKOUT) && adv && (st.phase == PH_DRIVE) |=> st.sda_oe == !$past(st.ackch))
    else $error("Acknowledge bit driven wrong.");
  chk_smart_read: assert property (
    acc_rd && (st.p_idx == IDX_SHIFT) && st.smart && held |=> st.fsm == ST_ACKOUT)
    else $error("Smart read did not acknowledge.");
  chk_send_skip_ack: assert property (
    acc_wr && (st.p_idx == IDX_CMD) && !wdat[FLUSH_BIT] && held && st.en
    && (wdat[1:0] == cmd_next_byte) && !st.target[DIR_BIT]
    |=> (st.fsm == ST_XFER) && !st.rd_byte)
    else $error("Send command took acknowledge.");
  chk_write_done: assert property (
    (st.fsm == ST_XFER) && adv && (st.phase == PH_FALL) && !st.rd_byte
    && (st.bitn == BIT_ACK_SLOT) && !acc_wr
    |=> st.f_wif || ((st.fsm == ST_XFER) && st.rd_byte))
    else $error("Write completion not flagged.");
  chk_berr_fresh: assert property (
    st.en && stop_seen && st.mon_fresh && !acc_wr |=> st.f_berr)
    else $error("Start then stop not flagged.");
  chk_bus_answer: assert property (
    st.pend |-> !hreadyout ##1 hreadyout)
    else $error("Bus answer not in one wait state.");

  cov_read_done: cover property ($rose(st.f_rif));
  cov_arb_lost: cover property ($rose(st.f_arb));
  cov_stop_sent: cover property ((st.fsm == ST_STOP) ##1 (st.fsm == ST_IDLE));
  cov_smart_read: cover property ((st.fsm == ST_ACKOUT) ##1 (st.fsm == ST_ACKOUT));

endmodule

// ===== imc_pkg.sv
package imc_pkg;

  // Clock and two-wire bit timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_SETUP = 6'h03;
  localparam logic [5:0] IDX_CMD = 6'h04;
  localparam logic [5:0] IDX_FLAGS = 6'h05;
  localparam logic [5:0] IDX_TARGET = 6'h07;
  localparam logic [5:0] IDX_SHIFT = 6'h08;

  // Field positions.
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned SMART_BIT = 1;
  localparam int unsigned ACKCH_BIT = 2;
  localparam int unsigned FLUSH_BIT = 3;
  localparam int unsigned RIF_BIT = 7;
  localparam int unsigned WIF_BIT = 6;
  localparam int unsigned HOLD_BIT = 5;
  localparam int unsigned ARB_BIT = 3;
  localparam int unsigned BERR_BIT = 2;
  localparam int unsigned DIR_BIT = 0;

  // Bit engine quarter phases and counts.
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [3:0] MON_LAST = 4'h8;
  localparam logic [3:0] MON_EDGE_OK = 4'h1;

  typedef enum logic [1:0] {
    cmd_nothing = 2'h0,
    cmd_restart = 2'h1,
    cmd_next_byte = 2'h2,
    cmd_stop = 2'h3
  } imc_cmd_t;

  typedef enum logic [1:0] {
    LS_UNKNOWN = 2'h0,
    LS_IDLE = 2'h1,
    LS_OWNER = 2'h2,
    LS_BUSY = 2'h3
  } imc_line_t;

  typedef enum logic [1:0] {
    OP_RSTART = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h2,
    OP_STOP = 2'h3
  } imc_op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WAITBUS = 7'h02,
    ST_START = 7'h04,
    ST_ACKOUT = 7'h08,
    ST_XFER = 7'h10,
    ST_HOLD = 7'h20,
    ST_STOP = 7'h40
  } imc_fsm_t;

endpackage

// ===== imc_slave_model.sv
`timescale 1ns/100ps
module imc_slave_model
  #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] RDATA = 8'h5a
  )
  (
  // Wired line levels.
  input wire logic scl,
  input wire logic sda,
  // SDA pull-down, high while the model drives the line.
  output logic sda_oe
  );
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  logic hit = 1'b0;
  logic rd = 1'b0;
  initial sda_oe = 1'b0;
  // A start or repeated start restarts the bit count and drops any match.
  always @(negedge sda)
  begin
    if (scl)
    begin
      cnt = 0;
      hit = 1'b0;
    end
  end
  // Sample on SCL rise, MSB first; acknowledge slots are not shifted in.
  always @(posedge scl)
  begin
    // A released SDA in an acknowledge slot is a NACK, which ends a read.
    if (cnt % 9 == 8 && sda)
      hit = 1'b0;
    if (cnt % 9 != 8)
      sh = {sh[6:0], sda};
    cnt = cnt + 1;
    if (cnt == 8)
    begin
      hit = (sh[7:1] == ADDR);
      rd = sh[0];
    end
  end
  // Change SDA only while SCL is low, so no false start or stop appears.
  always @(negedge scl)
  begin
    if (hit && cnt % 9 == 8 && (cnt == 8 || !rd))
      sda_oe <= 1'b1;
    else if (hit && rd && cnt >= 9 && cnt % 9 != 8)
      sda_oe <= !RDATA[7 - cnt % 9];
    else
      sda_oe <= 1'b0;
  end
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  import imc_pkg::*;
  localparam logic [6:0] SLV = 7'h50;
  localparam logic [7:0] RBYTE = 8'h5a;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic scl_oe;
  logic sda_oe;
  logic slv_oe;
  // A third open-drain driver stands in for another master on SDA.
  logic bus_sda_low = 1'b0;
  logic scl;
  logic sda;
  int error_cnt = 0;
  int checks = 0;
  int seed = 11;
  logic [31:0] r;
  logic [7:0] d;

  always #5 mclk = ~mclk;
  // Open-drain lines with pull-ups; the slave never stretches SCL.
  assign scl = !scl_oe;
  assign sda = !(sda_oe || slv_oe || bus_sda_low);

  imc_master #(.QTR(4)) uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  imc_slave_model #(.ADDR(SLV), .RDATA(RBYTE)) sl (.scl(scl), .sda(sda), .sda_oe(slv_oe));

  // Wait for hready high at a rising edge; registered outputs are steady at the negedge.
  task automatic wait_rdy();
    @(negedge mclk);
    while (hreadyout !== 1'b1)
      @(negedge mclk);
    r = hrdata;
    @(posedge mclk);
  endtask
  // One single-word AHB-Lite transfer, entered just after a rising edge.
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, idx, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_rdy();
  endtask
  // Poll the flags until the masked bits match; the watchdog bounds the wait.
  task automatic wait_flags(input logic [7:0] mask, input logic [7:0] val);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    while ((r[7:0] & mask) !== val)
      xfer(1'b0, IDX_FLAGS, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset state, read, stop, NACK, random writes, flush, disable.
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    xfer(1'b1, IDX_FLAGS, 8'h03);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r, 32'h0000_0000, "flags after reset")
    xfer(1'b1, IDX_SETUP, 8'h01);
    xfer(1'b1, IDX_FLAGS, 8'h02);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[1:0], 2'h0, "owner forced")
    xfer(1'b1, IDX_FLAGS, 8'h01);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[1:0], 2'h1, "idle not forced")
    $display("test reset and force done");
    xfer(1'b1, IDX_TARGET, {SLV, 1'b1});
    wait_flags(8'h80, 8'h80);
    `CHK(r[7:0], 8'ha2, "read flags")
    xfer(1'b0, IDX_SHIFT, 8'h00);
    `CHK(r[7:0], RBYTE, "read byte")
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[7:0], 8'ha2, "data read acted without smart mode")
    // Smart read with ACK chosen: the slave goes on with a second byte.
    xfer(1'b1, IDX_SETUP, 8'h03);
    xfer(1'b0, IDX_SHIFT, 8'h00);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[7:5], 3'h0, "smart read kept flags")
    wait_flags(8'h80, 8'h80);
    `CHK(r[7:0], 8'ha2, "second byte flags")
    xfer(1'b1, IDX_SETUP, 8'h01);
    xfer(1'b0, IDX_SHIFT, 8'h00);
    `CHK(r[7:0], RBYTE, "second byte after ACK")
    xfer(1'b1, IDX_CMD, 8'h07);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[7:5], 3'h0, "command left flags")
    xfer(1'b0, IDX_CMD, 8'h00);
    `CHK(r[7:0], 8'h04, "command readback")
    wait_flags(8'h03, 8'h01);
    $display("test read and stop done");
    xfer(1'b1, IDX_TARGET, {7'h11, 1'b0});
    wait_flags(8'h40, 8'h40);
    `CHK(r[7:0], 8'h72, "nack flags")
    xfer(1'b1, IDX_FLAGS, 8'h40);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[7:0], 8'h32, "write one clear")
    $display("test nack done");
    // Target first, then data, so no stale byte goes out.
    // target before data
    repeat (3)
    begin
      d = 8'($random(seed));
      xfer(1'b1, IDX_TARGET, {SLV, 1'b0});
      wait_flags(8'h40, 8'h40);
      xfer(1'b1, IDX_SHIFT, d);
      wait_flags(8'h40, 8'h40);
      `CHK(sl.sh, d, "byte on the wire")
      `CHK(r[4], 1'b0, "slave ack")
    end
    $display("test random writes done");
    xfer(1'b1, IDX_CMD, 8'h08);
    xfer(1'b0, IDX_TARGET, 8'h00);
    `CHK(r[7:0], 8'h00, "flush target")
    xfer(1'b0, IDX_SHIFT, 8'h00);
    `CHK(r[7:0], 8'h00, "flush shift")
    xfer(1'b0, IDX_CMD, 8'h00);
    `CHK(r[7:0], 8'h00, "flush reads zero")
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[1:0], 2'h0, "line after flush")
    xfer(1'b1, IDX_FLAGS, 8'h01);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[1:0], 2'h1, "enabled again after flush")
    // Another master pulls SDA low with SCL high, then lets go: start then stop.
    bus_sda_low <= 1'b1;
    repeat (8) @(posedge mclk);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[1:0], 2'h3, "foreign start not seen")
    bus_sda_low <= 1'b0;
    repeat (8) @(posedge mclk);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[2:0], 3'h5, "start then stop not flagged")
    xfer(1'b1, IDX_SETUP, 8'h00);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[1:0], 2'h0, "line while disabled")
    // An address write while the line state is unknown only raises the flags.
    xfer(1'b1, IDX_FLAGS, 8'hfc);
    xfer(1'b1, IDX_TARGET, {SLV, 1'b0});
    xfer(1'b0, IDX_FLAGS, 8'h00);
    `CHK(r[7:0], 8'h44, "target write on unknown line")
    $display("test flush and disable done");
    report_and_stop();
  end
  // Watchdog: the sequence needs well under 100 us.
  initial
  begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule
